// ### logic/sts_pkg.sv
// constants and types of the 800 Mb/s state trigger sequencer
// Overview of operation
// R1: two pods of 17 sampled channels
// R2: split label holds at most 32 channels
// R3: eight functions, exactly one active
// R4: per pod: 4 patterns, 2 ranges, or mix
// R5: non-split slots: all eight comparisons
// R6: split slots only equal or not equal
// R7: reordered labels only equal or not equal
// R8: four flags tested set/clear, never driven
// R9: arm-in usable as level event
// R10: immediate: any pattern, three flag/arm events
// R11: eventual: non-split, one pattern per level
// R12: store qualifier uses same pod comparators
// R13: ranges only non-split, one per pod ANDable
// R14: immediate miss returns to first level
// R15: eventual never returns to first level
// R16: fixed AND/OR order, limited combining
// R17: full-width pattern by ANDing split slots
// R18: no flag set or clear actions
// R19: split pattern uses slot in every pod
// R20: over-demand configuration rejected with error
// R21: trigger pulse one sample, position recorded
package sts_pkg;
	localparam int NPOD = 2;
	localparam int NCH = 17;
	localparam int NSLOT = 4;
	localparam int NSL = NPOD * NSLOT;
	localparam int NLEV = 4;
	localparam int NEV = 5;
	localparam logic [2:0] MAX_EV = 3'h3;
	localparam logic [5:0] LBL_MAX = 6'h20;
	// register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_TPOS = 8'h08;
	localparam logic [7:0] A_PODM = 8'h0C;
	localparam logic [7:0] A_STOR = 8'h10;
	localparam logic [7:0] A_VAL = 8'h20;
	localparam logic [7:0] A_SCTL = 8'h40;
	localparam logic [7:0] A_LVL = 8'h60;
	localparam logic [7:0] A_END = 8'h70;
	// field positions
	localparam int C_RUN = 0;
	localparam int C_STOP = 1;
	localparam int C_FN = 4;
	localparam int S_OP = 17;
	localparam int S_SPLIT = 20;
	localparam int S_REORD = 21;
	localparam int ST_EN = 8;
	// comparison codes
	localparam logic [2:0] OP_EQ = 3'h0;
	localparam logic [2:0] OP_NE = 3'h1;
	localparam logic [2:0] OP_LT = 3'h2;
	localparam logic [2:0] OP_LE = 3'h3;
	localparam logic [2:0] OP_GT = 3'h4;
	localparam logic [2:0] OP_GE = 3'h5;
	localparam logic [2:0] OP_IN = 3'h6;
	localparam logic [2:0] OP_OUT = 3'h7;
	// pod comparator modes
	localparam logic [1:0] PM_4PAT = 2'h0;
	localparam logic [1:0] PM_2RNG = 2'h1;
	localparam logic [1:0] PM_RP = 2'h2;
	// functions: 0 single, 1..3 immediate 2..4, 4..6 eventual 2..4, 7 run until stop
	localparam logic [2:0] FN_SINGLE = 3'h0;
	localparam logic [2:0] FN_EV = 3'h4;
	localparam logic [2:0] FN_RUN = 3'h7;
	// reset values
	localparam logic [2:0] FN_RST = 3'h0;
	localparam logic [3:0] PODM_RST = 4'h0;
	localparam logic [8:0] STOR_RST = 9'h000;

	typedef struct packed {
		logic reord;
		logic split;
		logic [2:0] op;
		logic [NCH-1:0] msk;
	} sts_sctl_t;

	typedef struct packed {
		logic join_and;
		logic ev_and;
		logic [NEV-1:0] evpol;
		logic [NEV-1:0] evsel;
		logic pat_and;
		logic [NSL-1:0] patsel;
	} sts_lvl_t;

	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} sts_state_t;
endpackage

// ### logic/sts_seq.sv
// state trigger sequencer with AHB-Lite register slave
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module sts_seq import sts_pkg::*; (
	// clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// probe pods and sample clock
	input wire logic smp_clk_i,
	input wire logic [NPOD*NCH-1:0] pod_i,
	// intermodule flags and arm-in
	input wire logic [3:0] flag_i,
	input wire logic arm_i,
	// acquisition outputs
	output logic trig_o,
	output logic store_o
);
	function automatic logic [5:0] popc(input logic [NPOD*NCH-1:0] v);
		popc = '0;
		for (int k = 0; k < NPOD*NCH; k++) begin
			popc = popc + {5'h00, v[k]};
		end
	endfunction

	function automatic logic [2:0] nlev(input logic [2:0] fn);
		if (fn == FN_SINGLE || fn == FN_RUN) begin
			nlev = 3'h1;
		end else if (fn < FN_EV) begin
			nlev = fn + 3'h1;
		end else begin
			nlev = fn - 3'h2;
		end
	endfunction

	function automatic logic cmp(input logic [NCH-1:0] x, input logic [NCH-1:0] v, input logic [2:0] op);
		case (op)
			OP_NE: cmp = x != v;
			OP_LT: cmp = x < v;
			OP_LE: cmp = x <= v;
			OP_GT: cmp = x > v;
			OP_GE: cmp = x >= v;
			default: cmp = x == v;
		endcase
	endfunction

	// synchronisers
	logic [NPOD*NCH-1:0] pod_s1_ff, pod_s2_ff;
	logic [3:0] flg_s1_ff, flg_s2_ff;
	logic arm_s1_ff, arm_s2_ff, sck_s1_ff, sck_s2_ff, sck_d_ff;
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pod_s1_ff <= '0;
			pod_s2_ff <= '0;
			flg_s1_ff <= '0;
			flg_s2_ff <= '0;
			arm_s1_ff <= 1'b0;
			arm_s2_ff <= 1'b0;
			sck_s1_ff <= 1'b0;
			sck_s2_ff <= 1'b0;
			sck_d_ff <= 1'b0;
		end else begin
			pod_s1_ff <= pod_i;
			pod_s2_ff <= pod_s1_ff;
			flg_s1_ff <= flag_i; // input only, never driven [R8] [R18]
			flg_s2_ff <= flg_s1_ff;
			arm_s1_ff <= arm_i; // [R9]
			arm_s2_ff <= arm_s1_ff;
			sck_s1_ff <= smp_clk_i;
			sck_s2_ff <= sck_s1_ff;
			sck_d_ff <= sck_s2_ff;
		end
	end

	// sample capture on the sample clock's rising edge
	logic [NCH-1:0] smp_ff [NPOD];
	logic [NEV-1:0] ev_ff;
	logic eval_ff;
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int p = 0; p < NPOD; p++) begin
				smp_ff[p] <= '0;
			end
			ev_ff <= '0;
			eval_ff <= 1'b0;
		end else begin
			eval_ff <= sck_s2_ff & ~sck_d_ff;
			if (sck_s2_ff && !sck_d_ff) begin
				for (int p = 0; p < NPOD; p++) begin
					smp_ff[p] <= pod_s2_ff[p*NCH +: NCH]; // [R1]
				end
				ev_ff <= {arm_s2_ff, flg_s2_ff};
			end
		end
	end

	// configuration registers
	logic [NCH-1:0] val_ff [NSL];
	sts_sctl_t sctl_ff [NSL];
	sts_lvl_t lvl_ff [NLEV];
	logic [3:0] podm_ff;
	logic [8:0] stor_ff;
	logic [2:0] fn_ff;
	logic run_req_ff, stop_req_ff;

	// per-slot hits and configuration checking
	logic [NSL-1:0] hit, rng, eqr;
	logic [NLEV-1:0] lhit;
	logic cfg_bad;
	always_comb begin
		logic [NCH-1:0] xm, vm, hm;
		logic [1:0] pm;
		logic [NSL-1:0] selall;
		logic sp;
		xm = '0;
		vm = '0;
		hm = '0;
		pm = '0;
		sp = 1'b0;
		hit = '0;
		rng = '0;
		eqr = '0;
		lhit = '0;
		cfg_bad = 1'b0;
		selall = stor_ff[NSL-1:0];
		for (int l = 0; l < NLEV; l++) begin
			if (3'(l) < nlev(fn_ff)) begin
				selall = selall | lvl_ff[l].patsel;
			end
		end
		for (int i = 0; i < NSL; i++) begin
			xm = smp_ff[i/NSLOT] & sctl_ff[i].msk;
			vm = val_ff[i] & sctl_ff[i].msk;
			eqr[i] = xm == vm;
		end
		for (int i = 0; i < NSL; i++) begin
			xm = smp_ff[i/NSLOT] & sctl_ff[i].msk;
			vm = val_ff[i] & sctl_ff[i].msk;
			hm = val_ff[i | 1] & sctl_ff[i].msk;
			pm = podm_ff[(i/NSLOT)*2 +: 2];
			rng[i] = sctl_ff[i].op == OP_IN || sctl_ff[i].op == OP_OUT;
			if (sctl_ff[i].split) begin
				sp = 1'b1;
				for (int p = 0; p < NPOD; p++) begin
					sp = sp & eqr[p*NSLOT + i%NSLOT]; // full width across pods [R17]
				end
				hit[i] = (sctl_ff[i].op == OP_NE) ? ~sp : sp;
			end else if (rng[i]) begin
				sp = xm >= vm && xm <= hm;
				hit[i] = (sctl_ff[i].op == OP_OUT) ? ~sp : sp; // [R5] [R13]
			end else begin
				hit[i] = cmp(xm, vm, sctl_ff[i].op); // [R5]
			end
			if ((sctl_ff[i].split || sctl_ff[i].reord) && sctl_ff[i].op > OP_NE) begin
				cfg_bad = 1'b1; // [R6] [R7] [R13]
			end
			if (sctl_ff[i].split) begin
				for (int p = 0; p < NPOD; p++) begin
					if (!sctl_ff[p*NSLOT + i%NSLOT].split) begin
						cfg_bad = 1'b1; // [R19]
					end
				end
				if (popc({sctl_ff[i%NSLOT].msk, sctl_ff[NSLOT + i%NSLOT].msk}) > LBL_MAX) begin
					cfg_bad = 1'b1; // [R2]
				end
			end
			if (rng[i] && !((i%NSLOT == 0 && pm != PM_4PAT) || (i%NSLOT == 2 && pm == PM_2RNG))) begin
				cfg_bad = 1'b1; // [R4] [R13]
			end
			if (rng[i] && selall[i | 1]) begin
				cfg_bad = 1'b1; // upper bound slot is not a pattern [R4] [R12]
			end
			if (i%NSLOT == 0 && pm > PM_RP) begin
				cfg_bad = 1'b1;
			end
		end
		for (int l = 0; l < NLEV; l++) begin
			if (3'(l) < nlev(fn_ff)) begin
				if (popc({29'h0, lvl_ff[l].evsel}) > {3'h0, MAX_EV}) begin
					cfg_bad = 1'b1; // [R10] [R16]
				end
				if (fn_ff >= FN_EV && fn_ff != FN_RUN) begin
					if (popc({26'h0, lvl_ff[l].patsel}) > 6'h01) begin
						cfg_bad = 1'b1; // [R11]
					end
					for (int i = 0; i < NSL; i++) begin
						if (lvl_ff[l].patsel[i] && sctl_ff[i].split) begin
							cfg_bad = 1'b1; // [R11]
						end
					end
				end
			end
		end
		// level: patterns, then events, then joined in a fixed order
		for (int l = 0; l < NLEV; l++) begin
			logic pv, evv, pr, er;
			logic [NEV-1:0] et;
			et = ~(ev_ff ^ lvl_ff[l].evpol); // [R8] [R9]
			pv = |lvl_ff[l].patsel;
			evv = |lvl_ff[l].evsel;
			pr = lvl_ff[l].pat_and ? &(hit | ~lvl_ff[l].patsel) : |(hit & lvl_ff[l].patsel); // [R4]
			er = lvl_ff[l].ev_and ? &(et | ~lvl_ff[l].evsel) : |(et & lvl_ff[l].evsel);
			if (pv && evv) begin
				lhit[l] = lvl_ff[l].join_and ? (pr & er) : (pr | er); // [R16]
			end else begin
				lhit[l] = (pv & pr) | (evv & er);
			end
		end
	end

	// sequencer
	sts_state_t st_ff;
	logic [1:0] lev_ff;
	logic err_ff;
	logic [31:0] scnt_ff, tpos_ff;
	logic imm, evt;
	assign imm = fn_ff != FN_SINGLE && fn_ff < FN_EV;
	assign evt = fn_ff >= FN_EV && fn_ff != FN_RUN;
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_ff <= ST_IDLE;
			lev_ff <= '0;
			err_ff <= 1'b0;
			trig_o <= 1'b0;
			tpos_ff <= '0;
		end else if (run_req_ff) begin
			lev_ff <= '0;
			trig_o <= 1'b0;
			err_ff <= cfg_bad; // [R20]
			st_ff <= cfg_bad ? ST_IDLE : ST_RUN; // [R3] [R20]
		end else if (stop_req_ff) begin
			st_ff <= ST_IDLE;
		end else if (eval_ff) begin
			trig_o <= 1'b0; // held for one sample period [R21]
			if (st_ff == ST_RUN && fn_ff != FN_RUN) begin
				if (lhit[lev_ff]) begin
					if (3'({1'b0, lev_ff}) == nlev(fn_ff) - 3'h1) begin
						st_ff <= ST_DONE;
						trig_o <= 1'b1; // [R21]
						tpos_ff <= scnt_ff; // [R21]
					end else begin
						lev_ff <= lev_ff + 2'h1; // [R14] [R15]
					end
				end else if (imm) begin
					lev_ff <= (lev_ff != 2'h0 && lhit[0]) ? 2'h1 : 2'h0; // [R14]
				end
			end
		end
	end

	// sample counter and store qualification
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			scnt_ff <= '0;
			store_o <= 1'b0;
		end else begin
			store_o <= eval_ff && st_ff != ST_IDLE &&
				(!stor_ff[ST_EN] || |(hit & stor_ff[NSL-1:0])); // [R12]
			if (run_req_ff) begin
				scnt_ff <= '0;
			end else if (eval_ff) begin
				scnt_ff <= scnt_ff + 32'h1;
			end
		end
	end

	// AHB-Lite slave, zero wait states
	logic wr_ff;
	logic [7:0] wa_ff;
	logic [31:0] rd;
	logic ap;
	assign ap = hsel_i && hready_i && htrans_i[1];
	always_comb begin
		logic [7:0] a;
		a = haddr_i[7:0];
		rd = '0;
		if (a == A_CTRL) begin
			rd[C_FN +: 3] = fn_ff;
		end else if (a == A_STAT) begin
			rd = {26'h0, lev_ff, err_ff, st_ff == ST_DONE, st_ff == ST_RUN, 1'b0};
		end else if (a == A_TPOS) begin
			rd = tpos_ff;
		end else if (a == A_PODM) begin
			rd[3:0] = podm_ff;
		end else if (a == A_STOR) begin
			rd[8:0] = stor_ff;
		end else if (a >= A_VAL && a < A_SCTL) begin
			rd[NCH-1:0] = val_ff[a[4:2]];
		end else if (a >= A_SCTL && a < A_LVL) begin
			rd[21:0] = sctl_ff[a[4:2]];
		end else if (a >= A_LVL && a < A_END) begin
			rd[20:0] = lvl_ff[a[3:2]];
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_ff <= 1'b0;
			wa_ff <= '0;
			hrdata_o <= '0;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			if (hready_i) begin
				wr_ff <= ap && hwrite_i;
				wa_ff <= haddr_i[7:0];
			end
			if (ap && !hwrite_i) begin
				hrdata_o <= rd;
			end
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fn_ff <= FN_RST;
			podm_ff <= PODM_RST;
			stor_ff <= STOR_RST;
			run_req_ff <= 1'b0;
			stop_req_ff <= 1'b0;
			for (int i = 0; i < NSL; i++) begin
				val_ff[i] <= '0;
				sctl_ff[i] <= '0;
			end
			for (int l = 0; l < NLEV; l++) begin
				lvl_ff[l] <= '0;
			end
		end else begin
			run_req_ff <= wr_ff && wa_ff == A_CTRL && hwdata_i[C_RUN];
			stop_req_ff <= wr_ff && wa_ff == A_CTRL && hwdata_i[C_STOP];
			if (wr_ff) begin
				if (wa_ff == A_CTRL) begin
					fn_ff <= hwdata_i[C_FN +: 3]; // [R3]
				end else if (wa_ff == A_PODM) begin
					podm_ff <= hwdata_i[3:0];
				end else if (wa_ff == A_STOR) begin
					stor_ff <= hwdata_i[8:0];
				end else if (wa_ff >= A_VAL && wa_ff < A_SCTL) begin
					val_ff[wa_ff[4:2]] <= hwdata_i[NCH-1:0];
				end else if (wa_ff >= A_SCTL && wa_ff < A_LVL) begin
					sctl_ff[wa_ff[4:2]] <= hwdata_i[21:0];
				end else if (wa_ff >= A_LVL && wa_ff < A_END) begin
					lvl_ff[wa_ff[3:2]] <= hwdata_i[20:0];
				end
			end
		end
	end

	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	cfg_reject_a: assert property (run_req_ff && cfg_bad |=> st_ff == ST_IDLE && err_ff) // [R20]
		else $error("bad configuration was started");
	run_start_a: assert property (run_req_ff && !cfg_bad |=> st_ff == ST_RUN && lev_ff == 2'h0 && !err_ff) // [R3]
		else $error("good configuration did not start");
	imm_reset_a: assert property (eval_ff && st_ff == ST_RUN && imm && !lhit[lev_ff] && !lhit[0]
		&& !run_req_ff && !stop_req_ff |=> lev_ff == 2'h0) // [R14]
		else $error("immediate miss kept level");
	ev_hold_a: assert property (eval_ff && st_ff == ST_RUN && evt && !lhit[lev_ff]
		&& !run_req_ff && !stop_req_ff |=> $stable(lev_ff)) // [R15]
		else $error("eventual miss moved level");
	ev_noback_a: assert property (st_ff == ST_RUN && evt && lev_ff != 2'h0 && !run_req_ff |=> lev_ff != 2'h0) // [R15]
		else $error("eventual returned to first level");
	trig_mark_a: assert property ($rose(trig_o) |-> st_ff == ST_DONE && tpos_ff == scnt_ff - 32'h1) // [R21]
		else $error("trigger without position");
	trig_len_a: assert property (trig_o && eval_ff |=> !trig_o) // [R21]
		else $error("trigger longer than one sample");
	stop_fn_a: assert property (st_ff == ST_RUN && fn_ff == FN_RUN |=> !$rose(trig_o)) // [R3]
		else $error("run until stop triggered");
	store_q_a: assert property (eval_ff && stor_ff[ST_EN] && !(|(hit & stor_ff[NSL-1:0])) |=> !store_o) // [R12]
		else $error("unqualified sample stored");
	split_op_a: assert property (sctl_ff[0].split && sctl_ff[0].op > OP_NE |-> cfg_bad) // [R6]
		else $error("split comparison not restricted");
	ready_a: assert property (hreadyout_o && !hresp_o)
		else $error("slave stalled or erred");

	imm_trig_c: cover property (st_ff == ST_RUN && imm ##1 $rose(trig_o));
	ev_trig_c: cover property (st_ff == ST_RUN && evt && fn_ff == 3'h6 ##1 $rose(trig_o));
	reject_c: cover property (run_req_ff && cfg_bad);
endmodule
`default_nettype wire

// ### verif/sts_target.sv
// probed target model: sample clock, pod channels, flags and arm-in
`timescale 1ns/1ns
`default_nettype none
module sts_target import sts_pkg::*; (
	// system clock
	input wire logic clock_i,
	// target side
	output logic smp_clk_o,
	output logic [NPOD*NCH-1:0] pod_o,
	output logic [3:0] flag_o,
	output logic arm_o
);
	initial begin
		smp_clk_o = 1'b0;
		pod_o = '0;
		flag_o = 4'h0;
		arm_o = 1'b0;
	end
	// one 400 ns frame; data held past the fall so the synced copy stays stable
	task automatic send(input logic [NPOD*NCH-1:0] p, input logic [3:0] f, input logic a);
		@(posedge clock_i);
		pod_o <= p;
		flag_o <= f;
		arm_o <= a;
		@(posedge clock_i);
		smp_clk_o <= 1'b1;
		repeat (4) @(posedge clock_i);
		smp_clk_o <= 1'b0;
		repeat (2) @(posedge clock_i);
	endtask
endmodule
`default_nettype wire

// ### verif/sts_seq_tb_top.sv
// self-checking bench for the state trigger sequencer
`timescale 1ns/1ns
`default_nettype none
module sts_seq_tb_top import sts_pkg::*;;
	localparam logic [16:0] PA = 17'h01111;
	localparam logic [16:0] PB = 17'h02222;
	localparam logic [16:0] PC = 17'h03333;
	localparam logic [16:0] M = 17'h1FFFF;
	localparam logic [16:0] MH = 17'h0FFFF;
	logic clock_i;
	logic nrst_i;
	logic hsel_i;
	logic [31:0] haddr_i;
	logic [1:0] htrans_i;
	logic hwrite_i;
	logic [2:0] hsize_i;
	logic [31:0] hwdata_i;
	logic [31:0] hrdata_o;
	logic hreadyout_o;
	logic hresp_o;
	logic smp_clk;
	logic [NPOD*NCH-1:0] pod;
	logic [3:0] flag;
	logic arm;
	logic trig_o;
	logic store_o;
	int err_total;
	int checks_done;
	logic [2:0] ops [8] = '{OP_LT, OP_LE, OP_GT, OP_GE, OP_NE, OP_EQ, OP_IN, OP_OUT};
	logic [16:0] smps [8] = '{17'h0FF, 17'h101, 17'h100, 17'h100, 17'h100, 17'h100, 17'h180, 17'h180};
	logic [7:0] exps = 8'b10010110;
	int n_store;
	int st_base;

	sts_seq dut (.clock_i(clock_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
		.hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .smp_clk_i(smp_clk), .pod_i(pod), .flag_i(flag),
		.arm_i(arm), .trig_o(trig_o), .store_o(store_o));
	sts_target tgt (.clock_i(clock_i), .smp_clk_o(smp_clk), .pod_o(pod), .flag_o(flag), .arm_o(arm));

	always #25 clock_i = ~clock_i;

	// store pulses last one cycle; count them at the falling edge where they stand
	always @(negedge clock_i) begin
		if (store_o === 1'b1) begin
			n_store++;
		end
	end

	task automatic wrap_up;
		$display("counts: mismatches %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (hreadyout_o !== 1'b1 && n < 20);
		if (hreadyout_o !== 1'b1) begin
			err_total++;
			wrap_up();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock_i);
		hsel_i <= 1'b1;
		haddr_i <= {24'h000000, a};
		htrans_i <= 2'h2;
		hwrite_i <= w;
		wait_rdy();
		htrans_i <= 2'h0;
		hwdata_i <= d;
		wait_rdy();
		q = hrdata_o;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		chk(nm, e, q & m);
	endtask
	function automatic logic [31:0] sctl(input logic [2:0] op, input logic sp, input logic ro, input logic [16:0] m);
		sctl = {10'h000, ro, sp, op, m};
	endfunction
	task automatic slot(input int i, input logic [16:0] v, input logic [31:0] c);
		wr(A_VAL + 8'(4 * i), {15'h0000, v});
		wr(A_SCTL + 8'(4 * i), c);
	endtask
	task automatic run(input logic [2:0] fn);
		wr(A_CTRL, {25'h0000000, fn, 4'h1});
	endtask
	task automatic smp(input logic [33:0] p, input logic [3:0] f, input logic a, input logic e);
		tgt.send(p, f, a);
		@(negedge clock_i);
		chk("trigger", {31'h00000000, e}, {31'h00000000, trig_o});
	endtask
	task automatic err_case(input logic [7:0] a, input logic [31:0] bad, input logic [31:0] good, input logic [2:0] fn);
		wr(a, bad);
		run(fn);
		rd("config error", A_STAT, 32'h00000008, 32'h00000008);
		wr(a, good);
	endtask

	initial begin
		clock_i = 1'b0;
		nrst_i = 1'b0;
		hsel_i = 1'b0;
		haddr_i = 32'h00000000;
		htrans_i = 2'h0;
		hwrite_i = 1'b0;
		hsize_i = 3'h2;
		hwdata_i = 32'h00000000;
		err_total = 0;
		checks_done = 0;
		repeat (5) @(posedge clock_i);
		nrst_i <= 1'b1;
		@(negedge clock_i);
		chk("reset outputs", 32'h00000008, {28'h0000000, hreadyout_o, hresp_o, trig_o, store_o});
		rd("ctrl reset", A_CTRL, {25'h0, FN_RST, 4'h0}, 32'hFFFFFFFF);
		rd("podmode reset", A_PODM, {28'h0, PODM_RST}, 32'hFFFFFFFF);
		rd("store reset", A_STOR, {23'h0, STOR_RST}, 32'hFFFFFFFF);
		rd("unmapped", 8'h74, 32'h00000000, 32'hFFFFFFFF);
		// single pattern, trigger held for one sample only
		slot(0, PA, sctl(OP_EQ, 1'b0, 1'b0, M));
		wr(A_LVL, 32'h00000001);
		run(FN_SINGLE);
		smp({17'h0, PB}, 4'h0, 1'b0, 1'b0);
		smp({17'h0, PA}, 4'h0, 1'b0, 1'b1);
		rd("trigger position", A_TPOS, 32'h00000001, 32'hFFFFFFFF);
		rd("status done", A_STAT, 32'h00000004, 32'h0000000E);
		smp({17'h0, PB}, 4'h0, 1'b0, 1'b0);
		// run until stop: qualified storing, store all, then stop
		st_base = n_store;
		wr(A_STOR, 32'h00000101);
		run(FN_RUN);
		smp({17'h0, PA}, 4'h0, 1'b0, 1'b0);
		smp({17'h0, PB}, 4'h0, 1'b0, 1'b0);
		smp({17'h0, PA}, 4'h0, 1'b0, 1'b0);
		chk("qualified stores", 32'h00000002, 32'(n_store - st_base));
		wr(A_STOR, 32'h00000000);
		smp({17'h0, PB}, 4'h0, 1'b0, 1'b0);
		chk("unqualified stores", 32'h00000003, 32'(n_store - st_base));
		wr(A_CTRL, {25'h0000000, FN_RUN, 4'h2});
		smp({17'h0, PA}, 4'h0, 1'b0, 1'b0);
		chk("stores after stop", 32'h00000003, 32'(n_store - st_base));
		rd("status stopped", A_STAT, 32'h00000000, 32'h00000006);
		// every comparison code, ranges on the even slot of mode 2
		wr(A_PODM, 32'h00000002);
		slot(1, 17'h00200, sctl(OP_EQ, 1'b0, 1'b0, M));
		for (int k = 0; k < 8; k++) begin
			slot(k < 6 ? 2 : 0, 17'h00100, sctl(ops[k], 1'b0, 1'b0, M));
			wr(A_LVL, k < 6 ? 32'h00000004 : 32'h00000001);
			run(FN_SINGLE);
			smp({17'h0, smps[k]}, 4'h0, 1'b0, exps[7-k]);
		end
		// immediate sequence: a gap sends it back to the first level
		wr(A_PODM, 32'h00000000);
		slot(0, PA, sctl(OP_EQ, 1'b0, 1'b0, M));
		slot(1, PB, sctl(OP_EQ, 1'b0, 1'b0, M));
		wr(A_LVL, 32'h00000001);
		wr(A_LVL + 8'h04, 32'h00000002);
		run(3'h1);
		smp({17'h0, PA}, 4'h0, 1'b0, 1'b0);
		smp({17'h0, PC}, 4'h0, 1'b0, 1'b0);
		smp({17'h0, PB}, 4'h0, 1'b0, 1'b0);
		smp({17'h0, PA}, 4'h0, 1'b0, 1'b0);
		smp({17'h0, PB}, 4'h0, 1'b0, 1'b1);
		// eventual sequence: gaps tolerated
		run(FN_EV);
		smp({17'h0, PA}, 4'h0, 1'b0, 1'b0);
		smp({17'h0, PC}, 4'h0, 1'b0, 1'b0);
		smp({17'h0, PC}, 4'h0, 1'b0, 1'b0);
		smp({17'h0, PB}, 4'h0, 1'b0, 1'b1);
		// each flag and arm-in as the only level event
		for (int e = 0; e < 5; e++) begin
			wr(A_LVL, (32'h1 << (9 + e)) | (32'h1 << (14 + e)));
			run(FN_SINGLE);
			smp({17'h0, PC}, 4'h0, 1'b0, 1'b0);
			smp({17'h0, PC}, e < 4 ? 4'h1 << e : 4'h0, e == 4, 1'b1);
		end
		// split label across both pods, 32 channels
		slot(0, 17'h0AAAA, sctl(OP_EQ, 1'b1, 1'b0, MH));
		slot(4, 17'h05555, sctl(OP_EQ, 1'b1, 1'b0, MH));
		wr(A_LVL, 32'h00000001);
		run(FN_SINGLE);
		smp({17'h05555, 17'h0AAAB}, 4'h0, 1'b0, 1'b0);
		smp({17'h05555, 17'h0AAAA}, 4'h0, 1'b0, 1'b1);
		err_case(A_SCTL, sctl(OP_EQ, 1'b1, 1'b0, M), sctl(OP_EQ, 1'b1, 1'b0, MH), FN_SINGLE);
		err_case(A_SCTL + 8'h10, sctl(OP_EQ, 1'b0, 1'b0, MH), sctl(OP_EQ, 1'b1, 1'b0, MH), FN_SINGLE);
		// rejected configurations
		wr(A_SCTL + 8'h10, sctl(OP_EQ, 1'b0, 1'b0, M));
		wr(A_SCTL, sctl(OP_EQ, 1'b0, 1'b0, M));
		err_case(A_SCTL, sctl(OP_LT, 1'b1, 1'b0, MH), sctl(OP_EQ, 1'b0, 1'b0, M), FN_SINGLE);
		err_case(A_SCTL, sctl(OP_GT, 1'b0, 1'b1, M), sctl(OP_EQ, 1'b0, 1'b0, M), FN_SINGLE);
		err_case(A_LVL, 32'h00000003, 32'h00000001, FN_EV);
		err_case(A_PODM, 32'h00000003, 32'h00000000, FN_SINGLE);
		err_case(A_LVL, 32'h00003E01, 32'h00000001, FN_SINGLE);
		run(FN_SINGLE);
		rd("error cleared", A_STAT, 32'h00000000, 32'h00000008);
		wrap_up();
	end
endmodule
`default_nettype wire
